// ===== rtl/otv_pkg.sv
// Package: command codes, field layout, limits, timing and carriers for the thermal and input overvoltage block
package otv_pkg;

	// ------------------------------------------------------------
	// Command codes
	// ------------------------------------------------------------
	localparam logic [7:0]  CMD_OT_ACTION   = 8'h50;
	localparam logic [7:0]  CMD_OT_WARN     = 8'h51;
	localparam logic [7:0]  CMD_VIN_OV      = 8'h55;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int          ACT_MODE_HI     = 7;
	localparam int          ACT_MODE_LO     = 6;
	localparam int          ACT_RETRY_HI    = 5;
	localparam int          ACT_RETRY_LO    = 3;
	localparam int          ACT_DELAY_HI    = 2;
	localparam int          ACT_DELAY_LO    = 0;
	localparam int          LIN_EXP_HI      = 15;
	localparam int          LIN_EXP_LO      = 11;
	localparam int          LIN_MAN_HI      = 10;
	localparam int          LIN_MAN_LO      = 0;

	// ------------------------------------------------------------
	// Reset values (stand-ins for the nonvolatile copy) and the exponents of the restore grids
	// ------------------------------------------------------------
	localparam logic [7:0]  OT_ACTION_RST   = 8'hB8;
	localparam logic [15:0] OT_WARN_RST     = 16'h0073;
	localparam logic [15:0] VIN_OV_RST      = 16'hF040;
	localparam logic [4:0]  WARN_STORE_EXP  = 5'h00;
	localparam logic [4:0]  VIN_STORE_EXP   = 5'h1E;

	// ------------------------------------------------------------
	// Action modes and retry codes
	// ------------------------------------------------------------
	localparam logic [1:0]  MODE_IGNORE     = 2'h0;
	localparam logic [1:0]  MODE_DELAYED    = 2'h1;
	localparam logic [1:0]  MODE_IMMEDIATE  = 2'h2;
	localparam logic [1:0]  MODE_UNTIL_COOL = 2'h3;
	localparam logic [2:0]  RETRY_NONE      = 3'h0;
	localparam logic [2:0]  RETRY_FOREVER   = 3'h7;

	// ------------------------------------------------------------
	// Limits in quarter units (quarter degree, quarter volt); WARN_OFF_DEG and WARN_MAX_DEG in whole degrees
	// ------------------------------------------------------------
	localparam int          Q_SHIFT         = 2;
	localparam int          Q_HALF          = 2;
	localparam int          WARN_MIN_Q      = 0;
	localparam int          WARN_MAX_Q      = 640;
	localparam int          WARN_OFF_Q      = 1020;
	localparam int          WARN_OFF_DEG    = 255;
	localparam int          WARN_MAX_DEG    = 160;
	localparam int          HYST_Q          = 80;
	localparam int          VIN_MIN_Q       = 16;
	localparam int          VIN_MAX_Q       = 80;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int          CLK_HZ          = 10_000_000;
	localparam int          MS_TIME_US      = 1000;
	localparam int          TICK_CYCLES     = (CLK_HZ / 1_000_000) * MS_TIME_US;
	localparam logic [15:0] DLY0_MS         = 16'h000A;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {OT_OFF, OT_RUN, THERMAL_SHUTDOWN_DELAY, OT_SHUT, OT_HICCUP, OT_LATCH} otv_ot_state_e;

	typedef struct packed {
		logic               valid;
		logic               write;
		logic               word;
		logic [7:0]         code;
		logic [15:0]        data;
	} otv_cmd_s;

	typedef struct packed {
		logic               valid;
		logic signed [15:0] temp_q;
		logic [15:0]        vin_q;
	} otv_telem_s;

	typedef struct packed {
		logic               status_temp;
		logic               thermal_fault_flag;
		logic               thermal_warning_flag;
		logic               cml_invalid_data;
		logic               vin_ov_detect;
		logic               stage_enable;
		logic               restart;
	} otv_status_s;

	typedef struct packed {
		logic signed [31:0] q;
		logic               exact;
	} otv_lin_s;

	typedef struct packed {
		logic [7:0]         ot_action;
		logic [15:0]        ot_warn;
		logic [15:0]        vin_ov;
		otv_ot_state_e      st;
		logic [15:0]        tick_cnt;
		logic [15:0]        tmr;
		logic [2:0]         tries;
		logic               stuck;
		logic               over;
		logic               cool;
		logic [15:0]        rd_data;
		logic               rd_valid;
		otv_status_s        stat;
		logic               alert_n;
	} otv_state_s;

	// ------------------------------------------------------------
	// Linear word to quarter units; exact is low if bits were lost
	// ------------------------------------------------------------
	function automatic otv_lin_s lin_to_q(input logic [15:0] w);
		otv_lin_s           r;
		logic signed [31:0] m;
		logic signed [4:0]  e;
		logic [4:0]         ne;
		logic [31:0]        mask;
		m = 32'(signed'(w[LIN_MAN_HI:LIN_MAN_LO])) <<< Q_SHIFT;
		e = signed'(w[LIN_EXP_HI:LIN_EXP_LO]);
		ne = 5'(-e);
		mask = (32'h1 << ne) - 32'h1;
		if (!e[4]) begin
			r.q = m <<< e;
			r.exact = 1'b1;
		end else begin
			r.q = m >>> ne;
			r.exact = ((m & signed'(mask)) == 32'sh0);
		end
		return r;
	endfunction

	// Hiccup multiple of the rise time for a delay code
	function automatic logic [2:0] hiccup_mult(input logic [2:0] d);
		logic [2:0] r;
		if (d == 3'h0)
			r = 3'h1;
		else if (d <= 3'h3)
			r = 3'h2;
		else if (d <= 3'h6)
			r = 3'h3;
		else
			r = 3'h4;
		return r;
	endfunction

endpackage

// ===== rtl/otv_fault_ctrl.sv
// Overtemperature and input overvoltage fault control: command registers, detection and shutdown sequencing
`timescale 1ns/1ps
`default_nettype none

module otv_fault_ctrl #(
	parameter int unsigned MS_CYCLES = otv_pkg::TICK_CYCLES
) (
	input  wire logic                 mclk,
	input  wire logic                 rst,
	input  wire otv_pkg::otv_cmd_s    cmd,
	input  wire otv_pkg::otv_telem_s  telem,
	input  wire logic [15:0]          ot_fault_limit,
	input  wire logic [7:0]           ton_rise_ms,
	input  wire logic                 output_enable,
	input  wire logic                 clear_faults,
	input  wire logic                 nvm_restore,
	output logic [15:0]               rd_data,
	output logic                      rd_valid,
	output otv_pkg::otv_status_s      status,
	output logic                      alert_n
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	otv_pkg::otv_state_s st;
	otv_pkg::otv_state_s next_st;

	otv_pkg::otv_lin_s   warn_lin;
	otv_pkg::otv_lin_s   fault_lin;
	otv_pkg::otv_lin_s   vin_lin;
	otv_pkg::otv_lin_s   wr_lin;
	logic signed [31:0]  release_q;
	logic signed [31:0]  temp_q;
	logic signed [31:0]  warn_deg;
	logic signed [31:0]  vin_clamp;
	logic                warn_off;
	logic                over_now;
	logic                cool_now;
	logic                warn_now;
	logic                tick;
	logic                wr_bad;
	logic                size_bad;
	logic                rd_bad;
	logic [1:0]          mode;
	logic [2:0]          retry;
	logic [2:0]          dly;
	logic [15:0]         hiccup_ms;

	assign rd_data  = st.rd_data;
	assign rd_valid = st.rd_valid;
	assign status   = st.stat;
	assign alert_n  = st.alert_n;

	// ------------------------------------------------------------
	// Threshold decode
	// ------------------------------------------------------------
	always_comb begin
		warn_lin  = otv_pkg::lin_to_q(st.ot_warn);
		fault_lin = otv_pkg::lin_to_q(ot_fault_limit);
		vin_lin   = otv_pkg::lin_to_q(st.vin_ov);
		wr_lin    = otv_pkg::lin_to_q(cmd.data);
		temp_q    = 32'(telem.temp_q);
		warn_off  = warn_lin.exact && (warn_lin.q == otv_pkg::WARN_OFF_Q);
		// Hysteresis falls back to a fixed band if the warning is unusable
		if (warn_off || (warn_lin.q > fault_lin.q))
			release_q = fault_lin.q - otv_pkg::HYST_Q;
		else
			release_q = warn_lin.q;
		over_now  = temp_q > fault_lin.q;
		cool_now  = temp_q < release_q;
		warn_now  = !warn_off && (temp_q >= warn_lin.q);
		mode      = st.ot_action[otv_pkg::ACT_MODE_HI:otv_pkg::ACT_MODE_LO];
		retry     = st.ot_action[otv_pkg::ACT_RETRY_HI:otv_pkg::ACT_RETRY_LO];
		dly       = st.ot_action[otv_pkg::ACT_DELAY_HI:otv_pkg::ACT_DELAY_LO];
		hiccup_ms = 16'(ton_rise_ms) * 16'(otv_pkg::hiccup_mult(dly));
		if (hiccup_ms == 16'h0000)
			hiccup_ms = 16'h0001;
		tick      = (st.tick_cnt == 16'(MS_CYCLES - 1));
	end

	// ------------------------------------------------------------
	// Write validation
	// ------------------------------------------------------------
	always_comb begin
		wr_bad = 1'b0;
		unique case (cmd.code)
			otv_pkg::CMD_OT_ACTION: begin
				wr_bad = cmd.word;
			end
			otv_pkg::CMD_OT_WARN: begin
				// Any resolution is kept as long as the value is in range
				wr_bad = !cmd.word ||
					!(((wr_lin.q >= otv_pkg::WARN_MIN_Q) && (wr_lin.q <= otv_pkg::WARN_MAX_Q)) ||
					  (wr_lin.exact && (wr_lin.q == otv_pkg::WARN_OFF_Q)));
			end
			otv_pkg::CMD_VIN_OV: begin
				wr_bad = !cmd.word || !wr_lin.exact ||
					(wr_lin.q < otv_pkg::VIN_MIN_Q) || (wr_lin.q > otv_pkg::VIN_MAX_Q);
			end
			default: begin
				wr_bad = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Transaction size check
	// ------------------------------------------------------------
	// Lets a wrong-size read survive a clear in the same cycle
	always_comb begin
		size_bad = 1'b0;
		unique case (cmd.code)
			otv_pkg::CMD_OT_ACTION: begin
				size_bad = cmd.word;
			end
			otv_pkg::CMD_OT_WARN, otv_pkg::CMD_VIN_OV: begin
				size_bad = !cmd.word;
			end
			default: begin
				size_bad = 1'b0;
			end
		endcase
		rd_bad = cmd.valid && !cmd.write && size_bad;
	end

	// ------------------------------------------------------------
	// Restore rounding
	// ------------------------------------------------------------
	always_comb begin
		warn_deg = (warn_lin.q + otv_pkg::Q_HALF) >>> otv_pkg::Q_SHIFT;
		if (warn_deg >= otv_pkg::WARN_OFF_DEG)
			warn_deg = otv_pkg::WARN_OFF_DEG;
		else if (warn_deg > otv_pkg::WARN_MAX_DEG)
			warn_deg = otv_pkg::WARN_MAX_DEG;
		else if (warn_deg < 0)
			warn_deg = 0;
		vin_clamp = vin_lin.q;
		if (vin_clamp < otv_pkg::VIN_MIN_Q)
			vin_clamp = otv_pkg::VIN_MIN_Q;
		else if (vin_clamp > otv_pkg::VIN_MAX_Q)
			vin_clamp = otv_pkg::VIN_MAX_Q;
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.rd_valid = 1'b0;
		next_st.stat.restart = 1'b0;

		// Millisecond base for delay and hiccup timing
		next_st.tick_cnt = tick ? 16'h0000 : st.tick_cnt + 16'h0001;

		// Register access; a rejected write leaves the old value in place
		if (cmd.valid && cmd.write) begin
			if (wr_bad) begin
				next_st.stat.cml_invalid_data = 1'b1;
			end else begin
				unique case (cmd.code)
					otv_pkg::CMD_OT_ACTION: next_st.ot_action = cmd.data[7:0];
					otv_pkg::CMD_OT_WARN:   next_st.ot_warn   = cmd.data;
					otv_pkg::CMD_VIN_OV:    next_st.vin_ov    = cmd.data;
					default: begin
					end
				endcase
			end
		end else if (cmd.valid) begin
			unique case (cmd.code)
				otv_pkg::CMD_OT_ACTION: begin
					next_st.rd_data  = {8'h00, st.ot_action};
					next_st.rd_valid = !cmd.word;
					next_st.stat.cml_invalid_data = st.stat.cml_invalid_data | cmd.word;
				end
				otv_pkg::CMD_OT_WARN, otv_pkg::CMD_VIN_OV: begin
					next_st.rd_data  = (cmd.code == otv_pkg::CMD_OT_WARN) ? st.ot_warn : st.vin_ov;
					next_st.rd_valid = cmd.word;
					next_st.stat.cml_invalid_data = st.stat.cml_invalid_data | !cmd.word;
				end
				default: begin
				end
			endcase
		end

		// Restore snaps both thresholds onto their stored grids
		if (nvm_restore) begin
			next_st.ot_warn = {otv_pkg::WARN_STORE_EXP, 11'(warn_deg)};
			next_st.vin_ov  = {otv_pkg::VIN_STORE_EXP, 11'(vin_clamp)};
		end

		// Detector levels only move on fresh telemetry
		if (telem.valid) begin
			next_st.over = over_now;
			next_st.cool = cool_now;
			next_st.stat.vin_ov_detect = 32'(telem.vin_q) > vin_lin.q;
		end

		// Sticky flags: a set in the clearing cycle wins
		if (clear_faults) begin
			next_st.stat.thermal_fault_flag   = 1'b0;
			next_st.stat.thermal_warning_flag = 1'b0;
			next_st.stat.cml_invalid_data     = 1'b0;
			if (rd_bad || (cmd.valid && cmd.write && wr_bad))
				next_st.stat.cml_invalid_data = 1'b1;
		end
		if (telem.valid && over_now)
			next_st.stat.thermal_fault_flag = 1'b1;
		if (telem.valid && warn_now)
			next_st.stat.thermal_warning_flag = 1'b1;

		// Shutdown sequencing
		unique case (st.st)
			otv_pkg::OT_OFF: begin
				next_st.stat.stage_enable = 1'b0;
				next_st.tries = 3'h0;
				next_st.stuck = 1'b0;
				if (output_enable) begin
					next_st.st = otv_pkg::OT_RUN;
					next_st.stat.stage_enable = 1'b1;
				end
			end
			otv_pkg::OT_RUN: begin
				next_st.stat.stage_enable = 1'b1;
				if (st.over && (mode != otv_pkg::MODE_IGNORE)) begin
					if (mode == otv_pkg::MODE_DELAYED) begin
						next_st.st  = otv_pkg::THERMAL_SHUTDOWN_DELAY;
						next_st.tmr = (dly == 3'h0) ? otv_pkg::DLY0_MS : 16'(dly);
					end else begin
						next_st.st = otv_pkg::OT_SHUT;
						next_st.stat.stage_enable = 1'b0;
					end
				end else if (telem.valid && !over_now) begin
					// A clean reading after start-up counts as success
					next_st.tries = 3'h0;
				end
			end
			otv_pkg::THERMAL_SHUTDOWN_DELAY: begin
				if (!st.over || (mode == otv_pkg::MODE_IGNORE)) begin
					next_st.st = otv_pkg::OT_RUN;
				end else if (tick) begin
					if (st.tmr <= 16'h0001) begin
						next_st.st = otv_pkg::OT_SHUT;
						next_st.stat.stage_enable = 1'b0;
					end else begin
						next_st.tmr = st.tmr - 16'h0001;
					end
				end
			end
			otv_pkg::OT_SHUT: begin
				next_st.stat.stage_enable = 1'b0;
				if (telem.valid && over_now)
					next_st.stuck = 1'b0;
				if (clear_faults && (mode == otv_pkg::MODE_UNTIL_COOL) && !st.cool && !st.over)
					next_st.stuck = 1'b1;
				if (retry == otv_pkg::RETRY_NONE) begin
					next_st.st = otv_pkg::OT_LATCH;
				end else if ((mode != otv_pkg::MODE_UNTIL_COOL) || (st.cool && !st.stuck)) begin
					next_st.st  = otv_pkg::OT_HICCUP;
					next_st.tmr = hiccup_ms;
				end
			end
			otv_pkg::OT_HICCUP: begin
				next_st.stat.stage_enable = 1'b0;
				if (tick) begin
					if (st.tmr > 16'h0001) begin
						next_st.tmr = st.tmr - 16'h0001;
					end else if ((retry != otv_pkg::RETRY_FOREVER) && (st.tries >= retry)) begin
						next_st.st = otv_pkg::OT_LATCH;
					end else begin
						if (retry != otv_pkg::RETRY_FOREVER)
							next_st.tries = st.tries + 3'h1;
						if (st.cool) begin
							next_st.st = otv_pkg::OT_RUN;
							next_st.stat.stage_enable = 1'b1;
							next_st.stat.restart = 1'b1;
						end else begin
							// Hot attempt: nothing switches, but it is spent
							next_st.tmr = hiccup_ms;
						end
					end
				end
			end
			otv_pkg::OT_LATCH: begin
				next_st.stat.stage_enable = 1'b0;
			end
			default: begin
				next_st.st = otv_pkg::OT_OFF;
			end
		endcase

		// Disable always wins and also ends a stuck fault
		if (!output_enable) begin
			next_st.st = otv_pkg::OT_OFF;
			next_st.stat.stage_enable = 1'b0;
			next_st.stat.restart = 1'b0;
		end

		next_st.stat.status_temp = next_st.stat.thermal_fault_flag |
			next_st.stat.thermal_warning_flag;
		next_st.alert_n = !(next_st.stat.status_temp | next_st.stat.cml_invalid_data);
	end

	// ------------------------------------------------------------
	// Register
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			st           <= '0;
			st.ot_action <= otv_pkg::OT_ACTION_RST;
			st.ot_warn   <= otv_pkg::OT_WARN_RST;
			st.vin_ov    <= otv_pkg::VIN_OV_RST;
			st.st        <= otv_pkg::OT_OFF;
			st.alert_n   <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

endmodule

`default_nettype wire

// ===== test/otv_fault_ctrl_assertions.sv
// Checker for the thermal and input overvoltage fault control ports
`timescale 1ns/1ps
`default_nettype none

module otv_chk #(
	parameter int unsigned MS_CYCLES = 10
) (
	input wire logic                 mclk,
	input wire logic                 rst,
	input wire otv_pkg::otv_cmd_s    cmd,
	input wire otv_pkg::otv_telem_s  telem,
	input wire logic [15:0]          ot_fault_limit,
	input wire logic [7:0]           ton_rise_ms,
	input wire logic                 output_enable,
	input wire logic                 clear_faults,
	input wire logic                 nvm_restore,
	input wire logic [15:0]          rd_data,
	input wire logic                 rd_valid,
	input wire otv_pkg::otv_status_s status,
	input wire logic                 alert_n
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	property p_rd;
		cmd.valid && !cmd.write && (cmd.word ? (cmd.code == 8'h51 || cmd.code == 8'h55) : cmd.code == 8'h50) |=> rd_valid;
	endproperty
	a_rd: assert property (p_rd) else $error("read not answered");
	property p_rd_cause;
		rd_valid |-> $past(cmd.valid) && !$past(cmd.write);
	endproperty
	a_rd_cause: assert property (p_rd_cause) else $error("answer without read");
	property p_bad_size;
		cmd.valid && cmd.write && cmd.word && cmd.code == 8'h50 |=> status.cml_invalid_data && !rd_valid;
	endproperty
	a_bad_size: assert property (p_bad_size) else $error("wrong size write not flagged");
	property p_unmap;
		cmd.valid && !(cmd.code inside {8'h50, 8'h51, 8'h55}) |=> !rd_valid;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped code answered");
	property p_fault;
		telem.valid && ot_fault_limit[15:11] == 5'h00 && telem.temp_q > $signed({ot_fault_limit[10:0], 2'b00})
			|=> status.thermal_fault_flag && status.status_temp && !alert_n;
	endproperty
	a_fault: assert property (p_fault) else $error("fault reading not flagged");
	property p_temp_bit;
		status.status_temp == (status.thermal_fault_flag || status.thermal_warning_flag);
	endproperty
	a_temp_bit: assert property (p_temp_bit) else $error("temperature bit wrong");
	property p_alert;
		status.thermal_fault_flag || status.thermal_warning_flag || status.cml_invalid_data |-> !alert_n;
	endproperty
	a_alert: assert property (p_alert) else $error("flag set without alert");
	property p_sticky;
		status.thermal_fault_flag && !clear_faults |=> status.thermal_fault_flag;
	endproperty
	a_sticky: assert property (p_sticky) else $error("fault flag lost");
	property p_vin_hold;
		!telem.valid |=> $stable(status.vin_ov_detect);
	endproperty
	a_vin_hold: assert property (p_vin_hold) else $error("detect moved without telemetry");
endmodule

bind otv_fault_ctrl otv_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (.mclk(mclk), .rst(rst), .cmd(cmd), .telem(telem),
	.ot_fault_limit(ot_fault_limit), .ton_rise_ms(ton_rise_ms), .output_enable(output_enable),
	.clear_faults(clear_faults), .nvm_restore(nvm_restore), .rd_data(rd_data), .rd_valid(rd_valid),
	.status(status), .alert_n(alert_n));

`default_nettype wire

// ===== test/otv_host.sv
// Bus host model issuing byte and word commands
`timescale 1ns/1ps
`default_nettype none

module otv_host (
	input  wire logic            mclk,
	input  wire logic [15:0]     rd_data,
	input  wire logic            rd_valid,
	output var otv_pkg::otv_cmd_s cmd
);
	initial cmd = '0;

	// Entered just after an edge; one-cycle strobe, answer one cycle later
	task automatic xfer(input logic w, input logic wd, input logic [7:0] c, input logic [15:0] d,
		output logic [15:0] q, output logic ok);
		cmd = '{valid: 1'b1, write: w, word: wd, code: c, data: wd ? d : {8'h00, d[7:0]}};
		@(posedge mclk);
		#1;
		// Answer stands only in the cycle after the taking edge
		ok = rd_valid;
		q = rd_data;
		// Released lines show garbage, not the last value
		cmd = '{valid: 1'b0, write: ~w, word: ~wd, code: ~c, data: ~d};
		@(posedge mclk);
		#1;
	endtask
endmodule

`default_nettype wire

// ===== test/otv_fault_ctrl_tb.sv
// Testbench for the thermal and input overvoltage fault control block
`timescale 1ns/1ps
`default_nettype none

module otv_fault_ctrl_tb;
	logic                 mclk;
	logic                 rst;
	otv_pkg::otv_cmd_s    cmd;
	otv_pkg::otv_telem_s  telem;
	logic [15:0]          ot_fault_limit;
	logic [7:0]           ton_rise_ms;
	logic                 output_enable;
	logic                 clear_faults;
	logic                 nvm_restore;
	logic [15:0]          rd_data;
	logic                 rd_valid;
	otv_pkg::otv_status_s status;
	logic                 alert_n;
	logic [15:0]          rq;
	logic                 rok;
	logic                 seen;
	int                   fails = 0;
	int                   cmp_count = 0;
	localparam logic [24:0] BAD [6] = '{{1'b1, 8'h50, 16'h0038}, {1'b0, 8'h51, 16'h0073}, {1'b1, 8'h51, 16'h07FF},
		{1'b1, 8'h51, 16'h00A1}, {1'b1, 8'h55, 16'hF00F}, {1'b1, 8'h55, 16'hF051}};
	localparam logic [23:0] GOOD [3] = '{{8'h55, 16'hF010}, {8'h55, 16'hF050}, {8'h51, 16'h00A0}};

	otv_fault_ctrl #(.MS_CYCLES(10)) uut (.mclk(mclk), .rst(rst), .cmd(cmd), .telem(telem),
		.ot_fault_limit(ot_fault_limit), .ton_rise_ms(ton_rise_ms), .output_enable(output_enable),
		.clear_faults(clear_faults), .nvm_restore(nvm_restore), .rd_data(rd_data), .rd_valid(rd_valid),
		.status(status), .alert_n(alert_n));
	otv_host host (.mclk(mclk), .rd_data(rd_data), .rd_valid(rd_valid), .cmd(cmd));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic report_and_stop;
		if (fails == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		cmp_count++;
		if (s !== e) begin
			fails++;
			$display("mismatch at %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic tm(input int t, input int v);
		telem = '{valid: 1'b1, temp_q: 16'(t * 4), vin_q: 16'(v)};
		cyc(1);
		telem.valid = 1'b0;
		cyc(1);
	endtask
	task automatic clr;
		clear_faults = 1'b1;
		cyc(1);
		clear_faults = 1'b0;
		cyc(1);
	endtask
	task automatic wr(input logic wd, input logic [7:0] c, input logic [15:0] d);
		host.xfer(1'b1, wd, c, d, rq, rok);
	endtask
	task automatic rd(input logic wd, input logic [7:0] c);
		host.xfer(1'b0, wd, c, 16'h0000, rq, rok);
	endtask
	task automatic fault_run(input logic [7:0] a);
		wr(1'b0, 8'h50, {8'h00, a});
		clr();
		tm(25, 40);
		tm(160, 40);
	endtask
	task automatic wait_restart(input int n);
		seen = 1'b0;
		repeat (n) begin
			cyc(1);
			if (status.restart === 1'b1)
				seen = 1'b1;
		end
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_regs;
		rd(1'b0, 8'h50);
		chk(rq, 16'h00B8);
		chk(rok, 1'b1);
		rd(1'b1, 8'h51);
		chk(rq, 16'h0073);
		rd(1'b1, 8'h55);
		chk(rq, 16'hF040);
		wr(1'b1, 8'h51, 16'hF193);
		rd(1'b1, 8'h51);
		chk(rq, 16'hF193);
		wr(1'b1, 8'h55, 16'h0010);
		nvm_restore = 1'b1;
		cyc(1);
		nvm_restore = 1'b0;
		cyc(1);
		rd(1'b1, 8'h51);
		chk(rq, 16'h0065);
		rd(1'b1, 8'h55);
		chk(rq, 16'hF040);
	endtask
	task automatic t_refuse;
		foreach (BAD[i]) begin
			clr();
			wr(BAD[i][24], BAD[i][23:16], BAD[i][15:0]);
			chk(status.cml_invalid_data, 1'b1);
			chk(alert_n, 1'b0);
		end
		rd(1'b1, 8'h51);
		chk(rq, 16'h0065);
		rd(1'b1, 8'h55);
		chk(rq, 16'hF040);
		rd(1'b0, 8'h51);
		chk(rok, 1'b0);
		rd(1'b1, 8'h52);
		chk(rok, 1'b0);
		clr();
		foreach (GOOD[i]) begin
			wr(1'b1, GOOD[i][23:16], GOOD[i][15:0]);
			rd(1'b1, GOOD[i][23:16]);
			chk(rq, GOOD[i][15:0]);
		end
		chk(status.cml_invalid_data, 1'b0);
	endtask
	task automatic t_vin;
		wr(1'b1, 8'h55, 16'hF040);
		tm(25, 65);
		chk(status.vin_ov_detect, 1'b1);
		tm(25, 64);
		chk(status.vin_ov_detect, 1'b0);
	endtask
	task automatic t_warn;
		wr(1'b1, 8'h51, 16'h0073);
		clr();
		tm(115, 40);
		chk(status.thermal_warning_flag, 1'b1);
		chk(alert_n, 1'b0);
		chk(status.status_temp, 1'b1);
		chk(status.thermal_fault_flag, 1'b0);
		wr(1'b1, 8'h51, 16'h00FF);
		clr();
		tm(140, 40);
		chk(status.thermal_warning_flag, 1'b0);
		chk(alert_n, 1'b1);
	endtask
	task automatic t_hyst;
		fault_run(8'hB8);
		chk(status.thermal_fault_flag, 1'b1);
		cyc(1);
		chk(status.stage_enable, 1'b0);
		tm(135, 40);
		wait_restart(40);
		chk(seen, 1'b0);
		tm(125, 40);
		wait_restart(40);
		chk(seen, 1'b1);
		chk(status.stage_enable, 1'b1);
	endtask
	task automatic t_shut;
		wr(1'b1, 8'h51, 16'h0073);
		for (int i = 0; i < 2; i++) begin
			fault_run(i == 0 ? 8'hB8 : 8'hF8);
			cyc(1);
			chk(status.stage_enable, 1'b0);
			tm(130, 40);
			wait_restart(40);
			chk(seen, 1'b0);
			tm(100, 40);
			wait_restart(40);
			chk(seen, 1'b1);
		end
	endtask
	task automatic t_stuck;
		fault_run(8'hF8);
		tm(130, 40);
		clr();
		tm(100, 40);
		wait_restart(40);
		chk(seen, 1'b0);
		tm(160, 40);
		tm(100, 40);
		wait_restart(40);
		chk(seen, 1'b1);
	endtask
	task automatic t_latch;
		for (int i = 0; i < 2; i++) begin
			fault_run(i == 0 ? 8'h80 : 8'h88);
			tm(130, 40);
			cyc(40);
			tm(100, 40);
			wait_restart(60);
			chk(seen, 1'b0);
			chk(status.stage_enable, 1'b0);
			output_enable = 1'b0;
			cyc(2);
			output_enable = 1'b1;
			cyc(4);
			chk(status.stage_enable, 1'b1);
		end
	endtask
	task automatic t_delay;
		for (int i = 0; i < 2; i++) begin
			fault_run(i == 0 ? 8'h7A : 8'h78);
			cyc(i == 0 ? 8 : 85);
			chk(status.stage_enable, 1'b1);
			cyc(i == 0 ? 17 : 25);
			chk(status.stage_enable, 1'b0);
			tm(100, 40);
			wait_restart(40);
			chk(seen, 1'b1);
		end
		fault_run(8'h38);
		cyc(30);
		chk(status.stage_enable, 1'b1);
		tm(100, 40);
	endtask

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	initial begin
		#2_000_000;
		fails++;
		report_and_stop;
	end
	initial begin
		rst = 1'b1;
		telem = '0;
		ot_fault_limit = 16'h0096;
		ton_rise_ms = 8'h01;
		output_enable = 1'b1;
		clear_faults = 1'b0;
		nvm_restore = 1'b0;
		repeat (8) @(posedge mclk);
		#1;
		rst = 1'b0;
		cyc(2);
		t_regs();
		t_refuse();
		t_vin();
		t_warn();
		t_hyst();
		t_shut();
		t_stuck();
		t_latch();
		t_delay();
		report_and_stop;
	end
endmodule

`default_nettype wire
